// ### hw/pmx_ctrl.sv
// Top of the pad select controller: AHB-Lite slave, strap capture and three select registers.
//
// Overview of operation
// - Three-bit read/write fields, reset to zero.
// - Fields forced zero at reset and compatibility.
// - Card data fields forced only with strap high.
// - Register eight holds six pad select fields.
// - Register nine holds five pad select fields.
// - Register ten holds two low fields.
`timescale 1ns/1ps
`default_nettype none

module pmx_ctrl (
    // Clock, reset and clock enable.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Device mode and strap inputs.
    input wire logic compat_mode,
    input wire logic static_valid,
    // Selection codes to the pad multiplexers.
    output pmx_pkg::pmx_sel_type pad_sel,
    // Strap level as captured after reset.
    output logic strap_captured
);

    // Writes follow the AHB pipeline: the address phase is remembered here, and the register
    // loads at the first enabled edge of the data phase, because only then does hwdata stand.
    // Pending write from the previous address phase, and its target.
    logic wr_pend_q;
    logic wr_pend_d;
    logic [1:0] wr_idx_q;
    logic [1:0] wr_idx_d;
    // Registered read data.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // Strap capture: armed after the first enabled edge past reset release.
    logic strap_armed_q;
    logic strap_armed_d;
    logic strap_q;
    logic strap_d;

    // Stored register values.
    logic [31:0] ctrl_eight;
    logic [31:0] ctrl_nine;
    logic [31:0] ctrl_ten;
    // Per-register force masks.
    logic [31:0] force_eight;
    logic [31:0] force_nine;
    logic [31:0] force_ten;

    // Address phase qualifiers.
    logic bus_active;
    logic read_hazard;

    // A transfer is taken when selected, active and the bus is ready.
    // Idle and busy transfer types leave every register alone.
    assign bus_active = hsel && htrans[pmx_pkg::HTRANS_ACTIVE_BIT] && hready;

    // A read that follows a write at once would see the old value, so it waits one cycle.
    assign read_hazard = wr_pend_q && hsel && htrans[pmx_pkg::HTRANS_ACTIVE_BIT] && !hwrite;

    // Ready is withheld while frozen or while the read hazard lasts; errors are never given.
    // The price of the hazard rule is one wait state on a read placed right behind a write,
    // which is cheaper than a bypass path from hwdata to the read multiplexer.
    assign hreadyout = ce && !read_hazard;
    // Every access ends with an OKAY response, unmapped ones included.
    assign hresp = 1'b0;
    // Read data comes from a flip-flop, so it holds through the whole data phase.
    assign hrdata = rdata_q;

    // Compatibility mode clears every field; the card data fields only when the strap was high.
    always_comb begin
        // Registers eight and ten have no strap dependent field.
        force_eight = compat_mode ? pmx_pkg::MASK_EIGHT : pmx_pkg::CTRL_RESET;
        force_ten = compat_mode ? pmx_pkg::MASK_TEN : pmx_pkg::CTRL_RESET;
        // Outside compat mode nothing is forced and writes land as given.
        force_nine = pmx_pkg::CTRL_RESET;
        if (compat_mode) begin
            // The three plain fields of register nine are always cleared.
            force_nine = pmx_pkg::MASK_NINE & ~pmx_pkg::STRAP_FIELDS_NINE;
            if (strap_q) begin
                // With the strap seen high the card data fields are cleared as well.
                force_nine = pmx_pkg::MASK_NINE;
            end
        end
    end

    // Bus next state: capture writes, sample reads, catch the strap once.
    always_comb begin
        // A pending write lives for exactly one enabled cycle.
        wr_pend_d = 1'b0;
        // The target and the read data hold until a new transfer replaces them.
        wr_idx_d = wr_idx_q;
        rdata_d = rdata_q;
        // Once armed, the strap latch stays armed until the next reset.
        strap_armed_d = 1'b1;
        strap_d = strap_q;
        // The strap is taken on the first enabled edge after reset release.
        if (!strap_armed_q) begin
            strap_d = static_valid;
        end
        if (bus_active && hreadyout) begin
            // A write only notes its target now; its data arrives in the next cycle.
            if (hwrite) begin
                wr_pend_d = 1'b1;
                wr_idx_d = pmx_pkg::pmx_decode(haddr);
            end else begin
                // Unmapped addresses read as zero; reserved bits are never stored.
                unique case (pmx_pkg::pmx_decode(haddr))
                    pmx_pkg::IDX_EIGHT: rdata_d = ctrl_eight;
                    pmx_pkg::IDX_NINE: rdata_d = ctrl_nine;
                    pmx_pkg::IDX_TEN: rdata_d = ctrl_ten;
                    pmx_pkg::IDX_NONE: rdata_d = pmx_pkg::CTRL_RESET;
                endcase
            end
        end
    end

    // Bus and strap registers; frozen while the clock enable is low.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Reset drops any half-done write and disarms the strap latch.
            wr_pend_q <= 1'b0;
            wr_idx_q <= pmx_pkg::IDX_NONE;
            rdata_q <= pmx_pkg::CTRL_RESET;
            strap_armed_q <= 1'b0;
            strap_q <= 1'b0;
        end else if (ce) begin
            // With the enable low a pending write simply waits, since ready is low too.
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            rdata_q <= rdata_d;
            strap_armed_q <= strap_armed_d;
            strap_q <= strap_d;
        end
    end

    // The captured strap is shown so that software and tests can see which rule applies.
    assign strap_captured = strap_q;

    // The three registers share the write data; the write enables, field masks and force masks differ, and
    // each enable is the registered address phase, so a write never sees a stale target.
    // Register eight: six pad select fields.
    pmx_sel_reg #(
        .FIELD_MASK(pmx_pkg::MASK_EIGHT)
    ) u_ctrl_eight (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .wr_en(wr_pend_q && (wr_idx_q == pmx_pkg::IDX_EIGHT)),
        .wr_data(hwdata),
        .force_mask(force_eight),
        .value(ctrl_eight)
    );

    // Register nine: five pad select fields, two of them strap dependent.
    pmx_sel_reg #(
        .FIELD_MASK(pmx_pkg::MASK_NINE)
    ) u_ctrl_nine (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .wr_en(wr_pend_q && (wr_idx_q == pmx_pkg::IDX_NINE)),
        .wr_data(hwdata),
        .force_mask(force_nine),
        .value(ctrl_nine)
    );

    // Register ten: two fields in the low six bits.
    pmx_sel_reg #(
        .FIELD_MASK(pmx_pkg::MASK_TEN)
    ) u_ctrl_ten (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .wr_en(wr_pend_q && (wr_idx_q == pmx_pkg::IDX_TEN)),
        .wr_data(hwdata),
        .force_mask(force_ten),
        .value(ctrl_ten)
    );

    // Extracts one selection field from a stored register word.
    // Kept as a function so that every pad takes its code in the same way.
    function automatic logic [pmx_pkg::SEL_W-1:0] field_at(
        input logic [31:0] word,
        input int lsb
    );
        return word[lsb +: pmx_pkg::SEL_W];
    endfunction : field_at

    // Pad routing comes straight from the stored fields, so it changes one cycle after a write.
    // No extra register sits on the codes: a pad switches at the edge that loads its field.
    always_comb begin
        // Register eight.
        pad_sel.sel_port3_clock_request = field_at(ctrl_eight, pmx_pkg::LSB_PORT3_CLKREQ);
        pad_sel.sel_serif1_data_out = field_at(ctrl_eight, pmx_pkg::LSB_SERIF1_DOUT);
        pad_sel.sel_port1_transmit = field_at(ctrl_eight, pmx_pkg::LSB_PORT1_TX);
        pad_sel.sel_port1_request_to_send = field_at(ctrl_eight, pmx_pkg::LSB_PORT1_RTS);
        pad_sel.sel_buffered_port3_clock = field_at(ctrl_eight, pmx_pkg::LSB_BPORT3_CLK);
        pad_sel.sel_host_reset_output = field_at(ctrl_eight, pmx_pkg::LSB_HOST_RESET);
        // Register nine.
        pad_sel.sel_card_data1 = field_at(ctrl_nine, pmx_pkg::LSB_CARD_DATA1);
        pad_sel.sel_card_data2 = field_at(ctrl_nine, pmx_pkg::LSB_CARD_DATA2);
        pad_sel.sel_slow_clock_output = field_at(ctrl_nine, pmx_pkg::LSB_SLOW_CLOCK);
        pad_sel.sel_serif1_data_in = field_at(ctrl_nine, pmx_pkg::LSB_SERIF1_DIN);
        pad_sel.sel_serif1_bit_clock = field_at(ctrl_nine, pmx_pkg::LSB_SERIF1_BCLK);
        // Register ten.
        pad_sel.sel_serif1_frame_sync = field_at(ctrl_ten, pmx_pkg::LSB_SERIF1_SYNC);
        pad_sel.sel_ports_bit_clock = field_at(ctrl_ten, pmx_pkg::LSB_PORTS_BCLK);
    end

endmodule : pmx_ctrl

`default_nettype wire

// ### hw/pmx_pkg.sv
// Package with register map, field layout and carriers for the pad select controller.
package pmx_pkg;

    // Byte offsets of the three select registers on the register bus.
    localparam logic [7:0] OFF_CTRL_EIGHT = 8'h00;
    localparam logic [7:0] OFF_CTRL_NINE = 8'h04;
    localparam logic [7:0] OFF_CTRL_TEN = 8'h08;

    // Register index codes produced by the address decoder.
    localparam logic [1:0] IDX_NONE = 2'h0;
    localparam logic [1:0] IDX_EIGHT = 2'h1;
    localparam logic [1:0] IDX_NINE = 2'h2;
    localparam logic [1:0] IDX_TEN = 2'h3;

    // Width of one selection field and the reset value of every register.
    localparam int SEL_W = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Bits that hold selection fields; every other bit is reserved and reads zero.
    localparam logic [31:0] MASK_EIGHT = 32'h3FE0_703F;
    localparam logic [31:0] MASK_NINE = 32'h071C_7FC0;
    localparam logic [31:0] MASK_TEN = 32'h0000_003F;

    // Fields of register nine that are cleared in compatibility mode only with the strap high.
    localparam logic [31:0] STRAP_FIELDS_NINE = 32'h071C_0000;

    // Field positions (least significant bit) in register eight.
    localparam int LSB_PORT3_CLKREQ = 27;
    localparam int LSB_SERIF1_DOUT = 24;
    localparam int LSB_PORT1_TX = 21;
    localparam int LSB_PORT1_RTS = 12;
    localparam int LSB_BPORT3_CLK = 3;
    localparam int LSB_HOST_RESET = 0;

    // Field positions in register nine.
    localparam int LSB_CARD_DATA1 = 24;
    localparam int LSB_CARD_DATA2 = 18;
    localparam int LSB_SLOW_CLOCK = 12;
    localparam int LSB_SERIF1_DIN = 9;
    localparam int LSB_SERIF1_BCLK = 6;

    // Field positions in register ten.
    localparam int LSB_SERIF1_SYNC = 3;
    localparam int LSB_PORTS_BCLK = 0;

    // AHB transfer type that starts a transfer (NONSEQ or SEQ have bit 1 set).
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Selection code for every pad, as driven to the pad multiplexers.
    typedef struct packed {
        logic [SEL_W-1:0] sel_port3_clock_request;
        logic [SEL_W-1:0] sel_serif1_data_out;
        logic [SEL_W-1:0] sel_port1_transmit;
        logic [SEL_W-1:0] sel_port1_request_to_send;
        logic [SEL_W-1:0] sel_buffered_port3_clock;
        logic [SEL_W-1:0] sel_host_reset_output;
        logic [SEL_W-1:0] sel_card_data1;
        logic [SEL_W-1:0] sel_card_data2;
        logic [SEL_W-1:0] sel_slow_clock_output;
        logic [SEL_W-1:0] sel_serif1_data_in;
        logic [SEL_W-1:0] sel_serif1_bit_clock;
        logic [SEL_W-1:0] sel_serif1_frame_sync;
        logic [SEL_W-1:0] sel_ports_bit_clock;
    } pmx_sel_type;

    // Maps a byte address to the index of the register it hits.
    function automatic logic [1:0] pmx_decode(input logic [31:0] addr);
        logic [1:0] idx;
        idx = IDX_NONE;
        if (addr[7:0] == OFF_CTRL_EIGHT) begin
            idx = IDX_EIGHT;
        end else if (addr[7:0] == OFF_CTRL_NINE) begin
            idx = IDX_NINE;
        end else if (addr[7:0] == OFF_CTRL_TEN) begin
            idx = IDX_TEN;
        end
        return idx;
    endfunction : pmx_decode

endpackage : pmx_pkg

// ### hw/pmx_sel_reg.sv
// One select register: masked write, reset to zero and forced clearing.
`timescale 1ns/1ps
`default_nettype none

module pmx_sel_reg #(
    parameter logic [31:0] FIELD_MASK = 32'hFFFF_FFFF
) (
    // Clock, reset and clock enable.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Write strobe and data from the bus slave.
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // Bits that must be held at zero this cycle.
    input wire logic [31:0] force_mask,
    // Stored register value.
    output logic [31:0] value
);

    // Current and next stored value; reserved bits are never stored.
    logic [31:0] value_q;
    logic [31:0] value_d;

    // Next value: a write loads the fields, and forcing overrides any write.
    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            value_d = wr_data & FIELD_MASK;
        end
        value_d = value_d & ~force_mask;
    end

    // State register; the reset takes the constant reset value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_q <= pmx_pkg::CTRL_RESET;
        end else if (ce) begin
            value_q <= value_d;
        end
    end

    assign value = value_q;

endmodule : pmx_sel_reg

`default_nettype wire

// ### test/pmx_ctrl_chk.sv
// Checker with port assertions for the pad select controller.
`timescale 1ns/1ps
`default_nettype none
module pmx_ctrl_chk (
    // Clock, reset and enable.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Bus side.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Mode, strap and pad codes.
    input wire logic compat_mode,
    input wire logic static_valid,
    input wire pmx_pkg::pmx_sel_type pad_sel,
    input wire logic strap_captured
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A write taken to one offset whose data phase then completes outside compat mode.
    sequence s_wr(logic [7:0] a);
        hsel && htrans[1] && hready && hwrite && haddr[7:0] == a ##1 hready && !compat_mode;
    endsequence
    property p_reset;
        $rose(hresetn) |-> pad_sel == 39'h0 && hrdata == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    property p_compat;
        compat_mode && ce |=> (pad_sel & 39'h7F_FFE0_7FFF) == 39'h0;
    endproperty
    a_compat: assert property (p_compat) else $error("compat did not clear codes");
    property p_card;
        compat_mode && ce && strap_captured |=> (pad_sel & 39'h00_001F_8000) == 39'h0;
    endproperty
    a_card: assert property (p_card) else $error("card codes not cleared");
    property p_strap;
        $rose(hresetn) && ce |=> strap_captured == $past(static_valid);
    endproperty
    a_strap: assert property (p_strap) else $error("strap level not captured");
    property p_wr_eight;
        s_wr(8'h00) |=> pad_sel.sel_port1_transmit == $past(hwdata[23:21])
            && pad_sel.sel_host_reset_output == $past(hwdata[2:0]);
    endproperty
    a_wr_eight: assert property (p_wr_eight) else $error("register eight misrouted");
    property p_wr_nine;
        s_wr(8'h04) |=> pad_sel.sel_slow_clock_output == $past(hwdata[14:12])
            && pad_sel.sel_serif1_data_in == $past(hwdata[11:9]);
    endproperty
    a_wr_nine: assert property (p_wr_nine) else $error("register nine misrouted");
    property p_wr_ten;
        s_wr(8'h08) |=> pad_sel[5:0] == $past(hwdata[5:0]);
    endproperty
    a_wr_ten: assert property (p_wr_ten) else $error("register ten misrouted");
    // Read data is loaded at the taking edge, so it shows the codes from before that edge.
    property p_rd_ten;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h08
            |=> hrdata == {26'h0, $past(pad_sel[5:0])};
    endproperty
    a_rd_ten: assert property (p_rd_ten) else $error("register ten read wrong");
    // A low clock enable freezes every register, so codes and read data keep still.
    property p_frozen;
        !ce |=> $stable(pad_sel) && $stable(hrdata);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while frozen");
endmodule : pmx_ctrl_chk
bind pmx_ctrl pmx_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .compat_mode(compat_mode), .static_valid(static_valid),
    .pad_sel(pad_sel), .strap_captured(strap_captured));
`default_nettype wire

// ### test/pmx_ctrl_test.sv
// Self-checking bench for the pad select controller.
`timescale 1ns/1ps
`default_nettype none
module pmx_ctrl_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic compat_mode = 1'b0;
    logic static_valid = 1'b1;
    logic ce = 1'b1; // Clock enable; low freezes the block.
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pmx_pkg::pmx_sel_type pad_sel;
    logic strap_captured;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] rd;
    logic [31:0] shadow [3]; // Expected register contents.
    logic [31:0] masks [3];
    // The single slave's ready is fed back as the bus ready.
    pmx_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .compat_mode(compat_mode),
        .static_valid(static_valid), .pad_sel(pad_sel), .strap_captured(strap_captured));
    initial begin
        forever #5 hclk = ~hclk;
    end
    task automatic fail(input string msg);
        n_fail++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask : fail
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
    endtask : check_word
    task automatic check_sel(input logic [38:0] exp);
        checks++;
        if (pad_sel !== exp) fail($sformatf("pad codes %h expected %h", pad_sel, exp));
    endtask : check_sel
    // Waits for hready sampled high at a rising edge; the bound catches a hung slave.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) fail("ready never came");
    endtask : wait_ready
    // Index 3 hits the unmapped word after register ten.
    task automatic bus_access(input int i, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= 32'(i * 4);
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus_access
    task automatic write_all(input logic [31:0] d);
        for (int i = 0; i < 4; i++) begin
            bus_access(i, 1'b1, (i < 3) ? d & masks[i] : d);
            if (i < 3) shadow[i] = d & masks[i];
        end
    endtask : write_all
    // Reads every word and compares the codes against the expected register contents.
    task automatic verify();
        for (int i = 0; i < 4; i++) begin
            bus_access(i, 1'b0, 32'h0);
            check_word(rd, (i < 3) ? shadow[i] : 32'h0);
            check_word({31'h0, hresp}, 32'h0);
        end
        check_sel({shadow[0][29:21], shadow[0][14:12], shadow[0][5:0], shadow[1][26:24],
            shadow[1][20:18], shadow[1][14:6], shadow[2][5:0]});
    endtask : verify
    task automatic do_reset(input logic sv);
        hresetn <= 1'b0;
        static_valid <= sv;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        shadow = '{default: 32'h0};
        check_word({31'h0, strap_captured}, {31'h0, sv});
    endtask : do_reset
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        masks = '{pmx_pkg::MASK_EIGHT, pmx_pkg::MASK_NINE, pmx_pkg::MASK_TEN};
        @(posedge hclk);
        do_reset(1'b1);
        verify();
        // All ones fills every field; the mixed word sets the fields to codes 1, 4, 5 and 6.
        write_all(32'hFFFF_FFFF);
        verify();
        write_all(32'h2C96_D3A5);
        verify();
        // A low enable freezes all state and holds ready low, so compat mode clears nothing.
        ce <= 1'b0;
        compat_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        check_word({31'h0, hreadyout}, 32'h0);
        compat_mode <= 1'b0;
        @(posedge hclk);
        ce <= 1'b1;
        verify();
        // Compat mode clears all codes and a write made meanwhile is lost.
        compat_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        bus_access(0, 1'b1, pmx_pkg::MASK_EIGHT);
        shadow = '{default: 32'h0};
        verify();
        compat_mode <= 1'b0;
        write_all(32'hD369_2C5A);
        verify();
        // With the strap low the card data codes survive compat mode.
        do_reset(1'b0);
        write_all(32'hFFFF_FFFF);
        compat_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        shadow = '{32'h0, pmx_pkg::STRAP_FIELDS_NINE, 32'h0};
        verify();
        compat_mode <= 1'b0;
        report_and_stop();
    end
    // The tests need well under 2000 cycles; this cuts a hang short.
    initial begin
        #50000;
        fail("watchdog expired");
        report_and_stop();
    end
endmodule : pmx_ctrl_test
`default_nettype wire
